// >>> sec_read_pkg.sv
package sec_read_pkg;

    // ************************************************************
    // command framing
    // ************************************************************
    localparam logic [7:0] OPCODE_SEC_READ = 8'h48;
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam logic [5:0] DUMMY_END = 6'h28;
    localparam logic [2:0] BYTE_START = 3'h0;

    // ************************************************************
    // security area layout
    // ************************************************************
    localparam int OFFSET_W = 10;
    localparam int SEC_REG_COUNT = 4;
    localparam int SEC_REG_BYTES = 256;
    localparam int AREA_BYTES = SEC_REG_COUNT * SEC_REG_BYTES;
    localparam logic [9:0] OFFSET_RESET = 10'h000;

    // ************************************************************
    // data path
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_ISSUE = 2'b01,
        FETCH_PUSH = 2'b10
    } fetch_e;

endpackage : sec_read_pkg

// >>> sec_byte_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module sec_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_wr_clk,
    input wire logic i_wr_reset_n,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_rd_clk,
    input wire logic i_rd_reset_n,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);

    localparam int AW = $clog2(DEPTH);

    // ************************************************************
    // storage and pointers
    // ************************************************************
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] rgray_q1;
    logic [AW:0] rgray_q2;
    logic [AW:0] wgray_q1;
    logic [AW:0] wgray_q2;
    logic [AW:0] next_wbin;
    logic [AW:0] next_rbin;
    logic wr_fire;
    logic rd_fire;

    assign next_wbin = wbin + 1'b1;
    assign next_rbin = rbin + 1'b1;
    // full compares gray codes so no binary value crosses the domains
    assign o_wr_ready = (wgray != {~rgray_q2[AW:AW-1], rgray_q2[AW-2:0]});
    assign o_rd_valid = (rgray != wgray_q2);
    assign wr_fire = i_wr_valid & o_wr_ready;
    assign rd_fire = i_rd_ready & o_rd_valid;
    assign o_rd_data = mem[rbin[AW-1:0]];

    // ************************************************************
    // write side
    // ************************************************************
    always_ff @(posedge i_wr_clk) begin
        if (wr_fire) begin
            mem[wbin[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_wr_clk or negedge i_wr_reset_n) begin
        if (!i_wr_reset_n) begin
            wbin <= '0;
            wgray <= '0;
        end else if (wr_fire) begin
            wbin <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
        end
    end

    always_ff @(posedge i_wr_clk or negedge i_wr_reset_n) begin
        if (!i_wr_reset_n) begin
            rgray_q1 <= '0;
            rgray_q2 <= '0;
        end else begin
            rgray_q1 <= rgray;
            rgray_q2 <= rgray_q1;
        end
    end

    // ************************************************************
    // read side
    // ************************************************************
    always_ff @(posedge i_rd_clk or negedge i_rd_reset_n) begin
        if (!i_rd_reset_n) begin
            rbin <= '0;
            rgray <= '0;
        end else if (rd_fire) begin
            rbin <= next_rbin;
            rgray <= next_rbin ^ (next_rbin >> 1);
        end
    end

    always_ff @(posedge i_rd_clk or negedge i_rd_reset_n) begin
        if (!i_rd_reset_n) begin
            wgray_q1 <= '0;
            wgray_q2 <= '0;
        end else begin
            wgray_q1 <= wgray;
            wgray_q2 <= wgray_q1;
        end
    end

endmodule : sec_byte_fifo

`default_nettype wire

// >>> security_register_read.sv
// Contract
// - opcode 48h, 24-bit address, dummy byte, then data
// - sample all inbound bits on rising clock
// - shift data out on falling clock edge
// - advance read address after every byte
// - only low ten bits count, wrap to zero
// - chip select high ends read, releases output
// - four 256-byte registers form 1 KB area
`timescale 1ns/1ns
`default_nettype none

module security_register_read (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic i_load_valid,
    output logic o_load_ready,
    input wire logic [9:0] i_load_addr,
    input wire logic [7:0] i_load_data
);

    // ************************************************************
    // link side: command capture on rising edge
    // ************************************************************
    logic [5:0] bit_cnt;
    logic [31:0] shift_in;
    logic [31:0] next_shift;
    logic addr_ready;
    logic data_phase;
    logic [sec_read_pkg::OFFSET_W-1:0] spi_addr;

    assign next_shift = {shift_in[30:0], i_si};

    // chip select high acts as the link reset, so a frame cut short leaves nothing behind
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt <= '0;
            shift_in <= '0;
        end else begin
            if (bit_cnt != sec_read_pkg::DUMMY_END) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (bit_cnt < sec_read_pkg::CMD_BITS) begin
                shift_in <= next_shift;
            end
        end
    end

    // upper address bits are not checked; the host keeps them zero
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            addr_ready <= 1'b0;
            spi_addr <= sec_read_pkg::OFFSET_RESET;
        end else if (bit_cnt == sec_read_pkg::CMD_BITS - 6'h01 &&
                     next_shift[31:24] == sec_read_pkg::OPCODE_SEC_READ) begin
            addr_ready <= 1'b1;
            spi_addr <= next_shift[sec_read_pkg::OFFSET_W-1:0];
        end
    end

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            data_phase <= 1'b0;
        end else if (bit_cnt == sec_read_pkg::DUMMY_END - 6'h01 && addr_ready) begin
            data_phase <= 1'b1;
        end
    end

    // ************************************************************
    // link side: data out on falling edge
    // ************************************************************
    logic rd_clk;
    logic rd_reset_n;
    logic [2:0] out_idx;
    logic [7:0] out_shift;
    logic rd_valid;
    logic rd_ready;
    logic [7:0] rd_data;

    assign rd_clk = ~i_sclk;
    assign rd_reset_n = ~i_cs_n;
    assign rd_ready = data_phase & (out_idx == sec_read_pkg::BYTE_START);
    assign o_so = out_shift[7];

    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            out_idx <= sec_read_pkg::BYTE_START;
            out_shift <= 8'h00;
            o_so_oe <= 1'b0;
        end else if (data_phase) begin
            out_idx <= out_idx + 1'b1;
            o_so_oe <= 1'b1;
            if (out_idx == sec_read_pkg::BYTE_START) begin
                out_shift <= rd_data;
            end else begin
                out_shift <= {out_shift[6:0], 1'b0};
            end
        end
    end

    // ************************************************************
    // system side: crossings
    // ************************************************************
    logic [1:0] cs_sync;
    logic [1:0] ar_sync;
    logic frame_off;
    logic wr_reset_n;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_sync <= 2'h3;
            ar_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[0], i_cs_n};
            ar_sync <= {ar_sync[0], addr_ready};
        end
    end

    assign frame_off = cs_sync[1];
    assign wr_reset_n = i_reset_n & ~frame_off;

    // ************************************************************
    // system side: security area and prefetch
    // ************************************************************
    logic [7:0] area [sec_read_pkg::AREA_BYTES];
    logic [7:0] area_q;
    logic [sec_read_pkg::OFFSET_W-1:0] rd_addr;
    sec_read_pkg::fetch_e fetch;
    logic started;
    logic wr_valid;
    logic wr_ready;

    // loads wait while a read frame owns the array port
    assign o_load_ready = (fetch == sec_read_pkg::FETCH_IDLE) & frame_off;
    assign wr_valid = (fetch == sec_read_pkg::FETCH_PUSH);

    // one array: register number in bits 9:8, byte within it in bits 7:0
    always_ff @(posedge i_clk) begin
        if (i_load_valid && o_load_ready) begin
            area[i_load_addr] <= i_load_data;
        end
        if (fetch == sec_read_pkg::FETCH_ISSUE && wr_ready) begin
            area_q <= area[rd_addr];
        end
    end

    // spi_addr is stable from addr_ready until chip select rises
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fetch <= sec_read_pkg::FETCH_IDLE;
            started <= 1'b0;
            rd_addr <= sec_read_pkg::OFFSET_RESET;
        end else if (frame_off) begin
            fetch <= sec_read_pkg::FETCH_IDLE;
            started <= 1'b0;
        end else begin
            unique case (fetch)
                sec_read_pkg::FETCH_IDLE: begin
                    if (ar_sync[1] && !started) begin
                        rd_addr <= spi_addr;
                        started <= 1'b1;
                        fetch <= sec_read_pkg::FETCH_ISSUE;
                    end
                end
                sec_read_pkg::FETCH_ISSUE: begin
                    if (wr_ready) begin
                        fetch <= sec_read_pkg::FETCH_PUSH;
                    end
                end
                sec_read_pkg::FETCH_PUSH: begin
                    if (wr_ready) begin
                        // ten-bit counter rolls 3FFh to 000h by itself
                        rd_addr <= rd_addr + 1'b1;
                        fetch <= sec_read_pkg::FETCH_ISSUE;
                    end
                end
                default: begin
                    fetch <= sec_read_pkg::FETCH_IDLE;
                end
            endcase
        end
    end

    // prefetch depth hides the crossing latency behind the dummy byte
    sec_byte_fifo #(
        .WIDTH(sec_read_pkg::DATA_W),
        .DEPTH(sec_read_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_wr_clk(i_clk),
        .i_wr_reset_n(wr_reset_n),
        .i_wr_valid(wr_valid),
        .o_wr_ready(wr_ready),
        .i_wr_data(area_q),
        .i_rd_clk(rd_clk),
        .i_rd_reset_n(rd_reset_n),
        .o_rd_valid(rd_valid),
        .i_rd_ready(rd_ready),
        .o_rd_data(rd_data)
    );

endmodule : security_register_read

`default_nettype wire

// >>> security_register_read_dummy_guard.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> sec_read_props.sv
`timescale 1ns/1ns
`default_nettype none
module sec_read_props (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic i_load_valid,
    input wire logic o_load_ready,
    input wire logic [9:0] i_load_addr,
    input wire logic [7:0] i_load_data
);
    // ****************************************
    // shadow of area and frame tracking
    // ****************************************
    logic [7:0] mem [1024];
    logic [39:0] sr;
    logic [15:0] cnt;
    logic [15:0] d;
    logic [9:0] at;
    assign d = cnt - 16'd40;
    assign at = sr[17:8] + d[12:3];
    always_ff @(posedge i_clk) begin
        if (i_load_valid && o_load_ready) mem[i_load_addr] <= i_load_data;
    end
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) cnt <= 16'h0;
        else cnt <= cnt + 16'h1;
    end
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) sr <= 40'h0;
        else if (cnt < 16'd40) sr <= {sr[38:0], i_si};
    end
    // ****************************************
    // assertions
    // ****************************************
    a_cs_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_cs_n |-> !o_so_oe) else $error("output enabled while deselected");
    a_quiet_cmd: assert property (@(negedge i_sclk) disable iff (i_cs_n)
        cnt < 16'd40 |-> !o_so_oe) else $error("output enabled before data");
    a_oe_start: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        cnt >= 16'd40 && sr[39:32] == sec_read_pkg::OPCODE_SEC_READ |-> o_so_oe)
        else $error("output not enabled after dummy");
    a_bad_opcode: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        cnt >= 16'd40 && sr[39:32] != sec_read_pkg::OPCODE_SEC_READ |-> !o_so_oe)
        else $error("output for foreign opcode");
    a_data_bit: assert property (@(posedge i_sclk) disable iff (i_cs_n)
        cnt >= 16'd40 && o_so_oe |-> o_so == mem[at][3'd7 - d[2:0]])
        else $error("wrong data bit");
    a_fall_only: assert property (@(posedge i_clk) disable iff (i_cs_n)
        o_so_oe && i_sclk && $past(i_sclk) |-> $stable(o_so))
        else $error("data changed while clock high");
    a_oe_hold: assert property (@(posedge i_clk) disable iff (i_cs_n)
        $past(o_so_oe) |-> o_so_oe) else $error("output dropped inside frame");
    a_ready_frame: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_cs_n [*4] |-> !o_load_ready) else $error("load open during frame");
    c_wrap: cover property (@(posedge i_sclk) cnt > 16'd40 && at == 10'h000);
    c_bad_op: cover property (@(posedge i_sclk) cnt == 16'd40 && !o_so_oe);
    c_abort: cover property (@(posedge i_clk) $rose(i_cs_n) && $past(o_so_oe));
endmodule : sec_read_props
`default_nettype wire

// >>> sec_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module sec_spi_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    // ****************************************
    // host frames, clock low between them
    // ****************************************
    logic [7:0] got [$];
    logic seen_oe;
    initial begin
        o_sclk = 1'b0;
        o_si = 1'b0;
        // a late, clean rising edge so the link logic surely sees its reset
        #1 o_cs_n = 1'b1;
    end
    task automatic xfer(input logic [7:0] op, input logic [9:0] a, input int nbits);
        logic [39:0] hdr;
        logic [7:0] b;
        hdr = {op, 14'h0, a, 8'hA5};
        got = {};
        seen_oe = 1'b0;
        #13 o_cs_n = 1'b0;
        for (int i = 0; i < 40 + nbits; i++) begin
            // released si toggles so a stale level is never mistaken for data
            o_si = (i < 40) ? hdr[39 - i] : ~o_si;
            #80 o_sclk = 1'b1;
            b = {b[6:0], i_so};
            seen_oe = seen_oe | i_so_oe;
            if (i >= 40 && (i - 40) % 8 == 7) got.push_back(b);
            #80 o_sclk = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        #40;
    endtask : xfer
endmodule : sec_spi_host
`default_nettype wire

// >>> tb_security_register_read.sv
`timescale 1ns/1ns
`default_nettype none
module tb_security_register_read;
    // ****************************************
    // bench
    // ****************************************
    logic i_clk = 1'b0;
    logic i_reset_n, sclk, cs_n, si, so, so_oe, load_valid, load_ready;
    logic [9:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] img [1024];
    int error_cnt = 0;
    int check_count = 0;
    wire so_line = so_oe ? so : 1'bz;
    security_register_read DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_load_valid(load_valid),
        .o_load_ready(load_ready), .i_load_addr(load_addr), .i_load_data(load_data));
    sec_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line),
        .i_so_oe(so_oe));
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    function automatic logic [7:0] exp_at(input logic [9:0] a, input int k);
        return img[a + 10'(k)];
    endfunction : exp_at
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        $display("mismatches %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic load_all;
        int n;
        for (int a = 0; a < 1024; a++) begin
            @(posedge i_clk);
            load_valid <= 1'b1;
            load_addr <= 10'(a);
            load_data <= img[a];
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (!load_ready && n < 200);
            if (n >= 200) begin
                chk("load ready", 8'h1, 8'h0);
                print_verdict();
            end
        end
        @(posedge i_clk);
        load_valid <= 1'b0;
    endtask : load_all
    task automatic rd(input logic [9:0] a, input int nbits);
        host.xfer(8'h48, a, nbits);
        chk("byte count", 8'(nbits / 8), 8'(host.got.size()));
        foreach (host.got[k]) chk("read byte", exp_at(a, k), host.got[k]);
        chk("released", 8'h0, {7'h0, so_oe});
    endtask : rd
    initial begin
        i_reset_n = 1'b0;
        load_valid = 1'b0;
        load_addr = 10'h000;
        load_data = 8'h00;
        void'($urandom(32'h2A37));
        foreach (img[i]) img[i] = 8'($urandom());
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        load_all();
        rd(10'h3FD, 32);
        rd(10'h0FF, 24);
        host.xfer(8'h0B, 10'h010, 16);
        chk("foreign opcode", 8'h0, {7'h0, host.seen_oe});
        rd(10'h123, 13);
        rd(10'h000, 16);
        repeat (6) rd(10'($urandom()), 8 + $urandom_range(0, 80));
        print_verdict();
    end
    initial begin
        // bound set over three times the length of the longest whole run
        #600000;
        chk("watchdog", 8'h0, 8'h1);
        print_verdict();
    end
endmodule : tb_security_register_read
bind security_register_read sec_read_props u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe),
    .i_load_valid(i_load_valid), .o_load_ready(o_load_ready), .i_load_addr(i_load_addr),
    .i_load_data(i_load_data));
`default_nettype wire
